//--- rtl/rcs_pkg.sv
package rcs_pkg;

    localparam int MAG_W = 9;
    localparam int PULSE_W = 8;

    // two-bit auxiliary clock select codes
    localparam logic [1:0] SEL_FLAG = 2'h0;
    localparam logic [1:0] SEL_COPY = 2'h1;
    localparam logic [1:0] SEL_DIV2 = 2'h2;
    localparam logic [1:0] SEL_DIV4 = 2'h3;

    localparam logic [PULSE_W-1:0] PULSE_RESET = 8'h00;
    localparam logic [1:0] DIV_RESET = 2'h0;

    typedef enum logic [1:0] {
        RCS_FLAG,
        RCS_COPY,
        RCS_DIV2,
        RCS_DIV4
    } rcs_pin_mode_e;

endpackage

//--- rtl/rcs_ref_clock_select.sv
// Function
// - channel D overrange output goes high when magnitude exceeds threshold
// - asserted overrange stays high at least the programmed minimum pulse length
// - channel D pin carries auxiliary clock when selected, synthesizer enabled, channel C clock on, no power-down and output enabled
// - select bits low or output disabled: channel D pin carries overrange flag
// - any strap select bit set: channel D gives undivided reference copy
// - divide-by-two or four on channel D only through register override
// - channel D clock only while channel C also produces a clock
// - power-down stops repeated reference and both auxiliary clock outputs
// - synthesizer enable high generates sampling clock; low disables and bypasses
// - reference select high picks single-ended input, low picks differential
// - repeated reference output reproduces the selected reference input
// - select one copy, two divide-by-two, three divide-by-four on channel C
`timescale 1ns/1ns
module rcs_ref_clock_select (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        clk_en,
    input  wire logic                        power_down_in,
    input  wire logic                        synth_enable_in,
    input  wire logic                        ref_input_select,
    input  wire logic                        single_ended_ref_in,
    input  wire logic                        diff_ref_in,
    input  wire logic [1:0]                  aux_clock_select,
    input  wire logic                        override_enable,
    input  wire logic [1:0]                  override_select_c,
    input  wire logic [1:0]                  override_select_d,
    input  wire logic                        clock_out_disable,
    input  wire logic [rcs_pkg::MAG_W-1:0]   magnitude_c,
    input  wire logic [rcs_pkg::MAG_W-1:0]   magnitude_d,
    input  wire logic [rcs_pkg::MAG_W-1:0]   overrange_threshold,
    input  wire logic [rcs_pkg::PULSE_W-1:0] overrange_min_pulse,
    output logic                             aux_out_c,
    output logic                             aux_out_d,
    output logic                             ref_clock_repeat_out,
    output logic                             sample_clock_out,
    output logic                             synth_active,
    output logic                             synth_bypass
);

    function automatic rcs_pkg::rcs_pin_mode_e code_to_mode(input logic [1:0] code);
        case (code)
            rcs_pkg::SEL_COPY: code_to_mode = rcs_pkg::RCS_COPY;
            rcs_pkg::SEL_DIV2: code_to_mode = rcs_pkg::RCS_DIV2;
            rcs_pkg::SEL_DIV4: code_to_mode = rcs_pkg::RCS_DIV4;
            default:           code_to_mode = rcs_pkg::RCS_FLAG;
        endcase
    endfunction

    function automatic logic pin_value(
            input rcs_pkg::rcs_pin_mode_e mode,
            input logic                   flag,
            input logic                   copy,
            input logic                   div2,
            input logic                   div4);
        case (mode)
            rcs_pkg::RCS_COPY: pin_value = copy;
            rcs_pkg::RCS_DIV2: pin_value = div2;
            rcs_pkg::RCS_DIV4: pin_value = div4;
            default:           pin_value = flag;
        endcase
    endfunction

    function automatic logic [rcs_pkg::PULSE_W-1:0] next_hold(
            input logic                        over,
            input logic [rcs_pkg::PULSE_W-1:0] cnt,
            input logic [rcs_pkg::PULSE_W-1:0] min_pulse);
        if (over) begin
            next_hold = min_pulse;
        end else if (cnt != rcs_pkg::PULSE_RESET) begin
            next_hold = cnt - 8'h01;
        end else begin
            next_hold = rcs_pkg::PULSE_RESET;
        end
    endfunction

    logic                        ref_prev;
    logic [1:0]                  div_count;
    logic [rcs_pkg::PULSE_W-1:0] hold_c;
    logic [rcs_pkg::PULSE_W-1:0] hold_d;
    rcs_pkg::rcs_pin_mode_e      mode_c;
    rcs_pkg::rcs_pin_mode_e      mode_d;

    // reference selection
    // input choice
    wire selected_ref = ref_input_select ? single_ended_ref_in : diff_ref_in;
    // synthesizer on uses selected reference; off bypasses to differential clock
    // bypass path relies on the differential input only
    wire next_sample_clock = synth_enable_in ? selected_ref : diff_ref_in;
    wire ref_rise = selected_ref & ~ref_prev;

    // counter advancing on reference rising edges
    wire [1:0] next_div_count = ref_rise ? div_count + 2'h1 : div_count;
    wire       div2_level = div_count[0];
    wire       div4_level = div_count[1];

    wire over_c = magnitude_c > overrange_threshold;
    wire over_d = magnitude_d > overrange_threshold;
    wire flag_c = over_c | (hold_c != rcs_pkg::PULSE_RESET);
    wire flag_d = over_d | (hold_d != rcs_pkg::PULSE_RESET);

    // power-down and enables gate both auxiliary clock outputs
    wire clocks_allowed = synth_enable_in & ~power_down_in & ~clock_out_disable;
    // channel C request from strap or override
    wire [1:0] code_c = override_enable ? override_select_c : aux_clock_select;
    wire       clock_c_on = clocks_allowed & (code_c != rcs_pkg::SEL_FLAG);
    // strap gives only the undivided copy; dividers only by override
    wire [1:0] code_d = override_enable ? override_select_d :
                        ((aux_clock_select != rcs_pkg::SEL_FLAG) ? rcs_pkg::SEL_COPY
                                                                 : rcs_pkg::SEL_FLAG);
    // channel D clock needs channel C clock
    wire clock_d_on = clocks_allowed & clock_c_on & (code_d != rcs_pkg::SEL_FLAG);

    // flag mode whenever the clock is not requested
    wire rcs_pkg::rcs_pin_mode_e want_c = clock_c_on ? code_to_mode(code_c)
                                                     : rcs_pkg::RCS_FLAG;
    wire rcs_pkg::rcs_pin_mode_e want_d = clock_d_on ? code_to_mode(code_d)
                                                     : rcs_pkg::RCS_FLAG;

    // switch only when current pin and new source are both low
    wire new_src_c = pin_value(want_c, flag_c, selected_ref, div2_level, div4_level);
    wire new_src_d = pin_value(want_d, flag_d, selected_ref, div2_level, div4_level);
    wire safe_c = ~aux_out_c & ~new_src_c;
    wire safe_d = ~aux_out_d & ~new_src_d;
    wire rcs_pkg::rcs_pin_mode_e next_mode_c = safe_c ? want_c : mode_c;
    wire rcs_pkg::rcs_pin_mode_e next_mode_d = safe_d ? want_d : mode_d;

    // a clock mode being left under power-down drops to low at once
    wire drop_c = power_down_in & (mode_c != rcs_pkg::RCS_FLAG);
    wire drop_d = power_down_in & (mode_d != rcs_pkg::RCS_FLAG);
    wire next_aux_c = drop_c ? 1'b0 :
                      pin_value(next_mode_c, flag_c, selected_ref, div2_level, div4_level);
    wire next_aux_d = drop_d ? 1'b0 :
                      pin_value(next_mode_d, flag_d, selected_ref, div2_level, div4_level);

    // repeated reference, present when synthesizer on and not powered down
    wire next_repeat = selected_ref & synth_enable_in & ~power_down_in;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_prev <= 1'b0;
            div_count <= rcs_pkg::DIV_RESET;
        end else if (clk_en) begin
            ref_prev <= selected_ref;
            div_count <= next_div_count;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_c <= rcs_pkg::PULSE_RESET;
            hold_d <= rcs_pkg::PULSE_RESET;
        end else if (clk_en) begin
            hold_c <= next_hold(over_c, hold_c, overrange_min_pulse);
            hold_d <= next_hold(over_d, hold_d, overrange_min_pulse);
        end
    end

    // pin source selection state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_c <= rcs_pkg::RCS_FLAG;
            mode_d <= rcs_pkg::RCS_FLAG;
        end else if (clk_en) begin
            mode_c <= drop_c ? rcs_pkg::RCS_FLAG : next_mode_c;
            mode_d <= drop_d ? rcs_pkg::RCS_FLAG : next_mode_d;
        end
    end

    // registered pin outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_out_c <= 1'b0;
            aux_out_d <= 1'b0;
        end else if (clk_en) begin
            aux_out_c <= next_aux_c;
            aux_out_d <= next_aux_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_clock_repeat_out <= 1'b0;
        end else if (clk_en) begin
            ref_clock_repeat_out <= next_repeat;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_clock_out <= 1'b0;
        end else if (clk_en) begin
            sample_clock_out <= next_sample_clock;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            synth_active <= 1'b0;
        end else if (clk_en) begin
            synth_active <= synth_enable_in & ~power_down_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            synth_bypass <= 1'b0;
        end else if (clk_en) begin
            synth_bypass <= ~synth_enable_in;
        end
    end

endmodule

//--- dv/rcs_ref_src.sv
`timescale 1ns/1ns
module rcs_ref_src #(parameter int HALF = 4) (
    input  wire logic clk,
    input  wire logic se_on,
    output logic      se_ref,
    output logic      diff_ref
);
    int   n = 0;
    logic r = 1'b0;
    always @(posedge clk) begin
        n <= (n == HALF - 1) ? 0 : n + 1;
        if (n == HALF - 1) r <= ~r;
    end
    assign se_ref = se_on & r;
    assign diff_ref = r;
endmodule

//--- dv/rcs_ref_clock_select_assertions.sv
`timescale 1ns/1ns
module rcs_chk (
    input wire logic                        clk,
    input wire logic                        reset_n,
    input wire logic                        clk_en,
    input wire logic                        power_down_in,
    input wire logic                        synth_enable_in,
    input wire logic                        ref_input_select,
    input wire logic                        single_ended_ref_in,
    input wire logic                        diff_ref_in,
    input wire logic                        clock_out_disable,
    input wire logic [rcs_pkg::MAG_W-1:0]   magnitude_d,
    input wire logic [rcs_pkg::MAG_W-1:0]   overrange_threshold,
    input wire logic [rcs_pkg::PULSE_W-1:0] overrange_min_pulse,
    input wire logic                        aux_out_c,
    input wire logic                        aux_out_d,
    input wire logic                        ref_clock_repeat_out,
    input wire logic                        sample_clock_out,
    input wire logic                        synth_active,
    input wire logic                        synth_bypass
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic       sel, was_en;
    logic [8:0] since;
    logic [3:0] dis_run;
    assign sel = ref_input_select ? single_ended_ref_in : diff_ref_in;
    // since: cycles after last over-threshold sample; dis_run: flag mode held
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {was_en, since, dis_run} <= {1'b0, 9'h1FF, 4'h0};
        end else begin
            was_en <= clk_en;
            if (clk_en) since <= (magnitude_d > overrange_threshold) ? 9'h000 : since + {8'h00, ~&since};
            if (clk_en) dis_run <= clock_out_disable ? dis_run + {3'h0, ~&dis_run} : 4'h0;
        end
    end
    act_follow_a: assert property (was_en |-> synth_active == $past(synth_enable_in && !power_down_in))
        else $error("synth_active wrong");
    byp_follow_a: assert property (was_en |-> synth_bypass == !$past(synth_enable_in))
        else $error("synth_bypass wrong");
    rep_follow_a: assert property (was_en |-> ref_clock_repeat_out == $past(sel && synth_enable_in && !power_down_in))
        else $error("repeat output wrong");
    smp_follow_a: assert property (was_en |-> sample_clock_out == $past(synth_enable_in ? sel : diff_ref_in))
        else $error("sample clock wrong");
    pd_stop_a: assert property (power_down_in && clk_en |=> !ref_clock_repeat_out && !synth_active)
        else $error("power down not stopping");
    flag_rise_a: assert property ((clock_out_disable && clk_en && magnitude_d <= overrange_threshold && !aux_out_d)[*4] ##1 (dis_run == 4'hF && clk_en && magnitude_d > overrange_threshold) |=> aux_out_d)
        else $error("overrange flag missing");
    min_hold_a: assert property ($fell(aux_out_d) && dis_run == 4'hF |-> since > {1'b0, overrange_min_pulse})
        else $error("overrange pulse short");
    pd_quiet_a: assert property ((power_down_in && clk_en && magnitude_d <= overrange_threshold && overrange_min_pulse < 8'h04)[*8] |=> !aux_out_d)
        else $error("pin D active in power down");
    cover property (synth_active && aux_out_c);
    cover property ($fell(aux_out_d) && dis_run == 4'hF);
    cover property ($fell(power_down_in));
endmodule
bind rcs_ref_clock_select rcs_chk i_chk (.*);

//--- dv/ref_clock_select_aux_out_test.sv
`timescale 1ns/1ns
module ref_clock_select_aux_out_test;
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, power_down_in = 1'b0, synth_enable_in = 1'b1;
    logic ref_input_select = 1'b0, override_enable = 1'b0, clock_out_disable = 1'b0, se_on = 1'b1;
    logic [1:0] aux_clock_select = 2'h0, override_select_c = 2'h0, override_select_d = 2'h0;
    logic [rcs_pkg::MAG_W-1:0] magnitude_c = 9'h000, magnitude_d = 9'h000, overrange_threshold = 9'h080;
    logic [rcs_pkg::PULSE_W-1:0] overrange_min_pulse = 8'h03;
    logic single_ended_ref_in, diff_ref_in, aux_out_c, aux_out_d, ref_clock_repeat_out;
    logic sample_clock_out, synth_active, synth_bypass;
    int   n_mismatch = 0, compares = 0;
    rcs_ref_clock_select i_dut (.*);
    rcs_ref_src i_src (.clk(clk), .se_on(se_on), .se_ref(single_ended_ref_in), .diff_ref(diff_ref_in));
    initial forever #5 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask
    task automatic chk(input int got, input int want);
        compares++;
        if (got != want) begin
            n_mismatch++;
            $display("[ERR] %0t count %0d, expected %0d", $time, got, want);
        end
    endtask
    // rising edges over 128 cycles: 16 reference periods
    task automatic edges(output int nc, output int nd, output int nr);
        logic lc, ld, lr;
        {nc, nd, nr} = {32'd0, 32'd0, 32'd0};
        tick(16);
        repeat (128) begin
            {lc, ld, lr} = {aux_out_c, aux_out_d, ref_clock_repeat_out};
            tick(1);
            nc += int'(aux_out_c === 1'b1 && lc === 1'b0);
            nd += int'(aux_out_d === 1'b1 && ld === 1'b0);
            nr += int'(ref_clock_repeat_out === 1'b1 && lr === 1'b0);
        end
    endtask
    task automatic t_clocks();
        int c, d, r;
        for (int k = 1; k < 4; k++) begin
            {override_enable, aux_clock_select} = {1'b0, 2'(k)};
            edges(c, d, r);
            chk(c, 16 >> (k - 1));
            chk(d, 16);
            chk(r, 16);
            {override_enable, override_select_c, override_select_d} = {1'b1, 2'(k), 2'(k)};
            edges(c, d, r);
            chk(d, 16 >> (k - 1));
        end
        $display("t_clocks done");
    endtask
    task automatic t_gate();
        int c, d, r;
        {override_select_c, override_select_d} = {2'h0, 2'h1};
        edges(c, d, r);
        chk(d, 0);
        {override_select_c, power_down_in} = {2'h1, 1'b1};
        edges(c, d, r);
        chk(c + d + r, 0);
        {power_down_in, synth_enable_in, se_on} = 3'h0;
        edges(c, d, r);
        chk(c, 0);
        {synth_enable_in, ref_input_select, se_on} = 3'h7;
        edges(c, d, r);
        chk(r, 16);
        $display("t_gate done");
    endtask
    task automatic t_flag();
        int h;
        {override_enable, aux_clock_select, clock_out_disable} = {1'b0, 2'h0, 1'b1};
        tick(20);
        for (int i = 0; i < 3; i++) begin
            overrange_min_pulse = (i == 2) ? 8'h00 : 8'h03;
            magnitude_d = overrange_threshold + 9'(i > 0);
            tick(1);
            {magnitude_d, h} = {9'h000, 32'd0};
            repeat (12) begin
                h += int'(aux_out_d === 1'b1);
                tick(1);
            end
            chk(h, (i == 0) ? 0 : int'(overrange_min_pulse) + 1);
        end
        $display("t_flag done");
    endtask
    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        tick(3);
        reset_n = 1'b1;
        t_clocks();
        t_gate();
        t_flag();
        wrap_up();
    end
endmodule
